// *** hdl/switch_global_control_regs.vh ***
`ifndef SWITCH_GLOBAL_CONTROL_REGS_VH
`define SWITCH_GLOBAL_CONTROL_REGS_VH

// Register offsets on the register access port.
`define REG_PORT3_CTRL 8'h06
`define REG_STORM_LOW 8'h07
`define REG_FACTORY_A 8'h08
`define REG_FACTORY_B 8'h09
`define REG_FACTORY_C 8'h0a

// Field positions in the port 3 control register.
`define DUPLEX_BIT 6
`define FLOW_BIT 5
`define SPEED_BIT 4
`define NULL_VID_BIT 3
`define STORM_HIGH_MSB 2

// Reset values and constant read values.
`define FLOW_RST 1'b1
`define SPEED_RST 1'b0
`define DUPLEX_RST 1'b0
`define NULL_VID_RST 1'b0
`define STORM_HIGH_RST 3'h0
`define STORM_LOW_RST 8'h63
`define FACTORY_A_VAL 8'h00
`define FACTORY_B_VAL 8'h24
`define FACTORY_C_VAL 8'h35
`define UNMAPPED_VAL 8'h00

// Timing.
`define SYS_CLK_MHZ 250
`define STORM_PERIOD_100_MS 67
`define STORM_PERIOD_10_MS 500
`define STRAP_SETTLE_CYC 2'h2

`endif

// *** hdl/storm_limiter.v ***
`timescale 1ns/1ps
`default_nettype none
module storm_limiter #(
   parameter CNT_W = 27,
   parameter [CNT_W-1:0] PERIOD_FAST_CYC = 27'h0ff_95b0,
   parameter [CNT_W-1:0] PERIOD_SLOW_CYC = 27'h773_5940
)(
   input wire sys_clk,
   input wire rstn,
   input wire speed_10,
   input wire [10:0] threshold,
   input wire block_in,
   output reg block_drop,
   output reg period_start
);
   reg [CNT_W-1:0] timer;
   reg [10:0] count;
   wire boundary;

   assign boundary = (timer == {CNT_W{1'b0}});

   // The period follows the port rate; a rate change takes effect at the next boundary.
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         timer <= {CNT_W{1'b0}};
         period_start <= 1'b0;
      end
      else
      begin
         period_start <= boundary;
         if (boundary)
            timer <= (speed_10 ? PERIOD_SLOW_CYC : PERIOD_FAST_CYC) - {{(CNT_W-1){1'b0}}, 1'b1};
         else
            timer <= timer - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // A block arriving on the boundary counts toward the new period, so none is lost.
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         count <= 11'h000;
         block_drop <= 1'b0;
      end
      else
      begin
         block_drop <= 1'b0;
         if (boundary)
         begin
            if (block_in && (threshold != 11'h000))
               count <= 11'h001;
            else
               count <= 11'h000;
            block_drop <= block_in && (threshold == 11'h000);
         end
         else if (block_in)
         begin
            if (count < threshold)
               count <= count + 11'h001;
            else
               block_drop <= 1'b1;
         end
      end
   end
endmodule // storm_limiter
`default_nettype wire

// *** hdl/switch_global_control_regs.v ***
// Notes on behaviour
// - Control bit 5 enables full-duplex flow control on the port 3 MII interface.
// - Flow-control bit loads from its strap pin at reset; default enabled.
// - Control bit 4 selects port 3 rate: one is 10 Mbps, zero 100 Mbps.
// - Speed bit loads from the speed strap pin at reset; default 100 Mbps.
// - Control bit 3 replaces a null VLAN ID with the port default; resets zero.
// - Storm threshold is 11 bits of 64-byte blocks, high three bits then low byte.
// - Storm period is 67 ms at 100 Mbps and 500 ms at 10 Mbps.
// - Storm threshold resets to 0x063, a one percent rate.
// - Three factory-test registers read 0x00, 0x24, 0x35 and ignore writes.
// - Control bit 6 selects port 3 half duplex; strap default is full duplex.
`timescale 1ns/1ps
`default_nettype none
`include "switch_global_control_regs.vh"
module switch_global_control_regs #(
   parameter NUM_PORTS = 3,
   parameter CNT_W = 27,
   parameter PERIOD_100_CYC = `STORM_PERIOD_100_MS * `SYS_CLK_MHZ * 1000,
   parameter PERIOD_10_CYC = `STORM_PERIOD_10_MS * `SYS_CLK_MHZ * 1000
)(
   input wire sys_clk,
   input wire rstn,
   input wire [7:0] reg_addr,
   input wire reg_wr,
   input wire [7:0] reg_wdata,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   output reg reg_rvalid,
   input wire flow_control_strap_pin,
   input wire cpu_port_speed_strap_pin,
   input wire duplex_strap_pin,
   input wire [NUM_PORTS-2:0] port_speed_10,
   input wire [NUM_PORTS-1:0] bcast_block,
   output wire [NUM_PORTS-1:0] bcast_drop,
   output wire [NUM_PORTS-1:0] storm_period_start,
   output reg port3_flow_control_en,
   output reg port3_speed_10,
   output reg port3_half_duplex,
   output reg null_vid_replace,
   output wire [10:0] storm_threshold,
   output reg strap_loaded
);
   localparam [CNT_W-1:0] FAST_CYC = PERIOD_100_CYC[CNT_W-1:0];
   localparam [CNT_W-1:0] SLOW_CYC = PERIOD_10_CYC[CNT_W-1:0];

   reg [2:0] strap_meta;
   reg [2:0] strap_sync;
   reg [1:0] settle;
   reg [2:0] storm_high;
   reg [7:0] storm_low;
   reg [7:0] next_rdata;
   wire strap_capture;
   wire ctrl_wr;
   wire low_wr;
   wire [7:0] ctrl_image;
   wire [NUM_PORTS-1:0] speed_vec;

   // Address compare shared by the write strobes and the read decode.
   function addr_hit;
      input [7:0] addr;
      input [7:0] offset;
      begin
         addr_hit = (addr == offset);
      end
   endfunction

   // Strap pins are asynchronous to sys_clk, so they pass two flip-flops first.
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_meta <= 3'h0;
         strap_sync <= 3'h0;
      end
      else
      begin
         strap_meta <= {duplex_strap_pin, cpu_port_speed_strap_pin, flow_control_strap_pin};
         strap_sync <= strap_meta;
      end
   end

   // The straps are caught once the synchroniser has filled after reset release.
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         settle <= 2'h0;
         strap_loaded <= 1'b0;
      end
      else if (!strap_loaded)
      begin
         if (settle == `STRAP_SETTLE_CYC)
            strap_loaded <= 1'b1;
         else
            settle <= settle + 2'h1;
      end
   end

   assign strap_capture = !strap_loaded && (settle == `STRAP_SETTLE_CYC);

   // Writes before the strap capture are ignored so the strap value cannot be lost.
   assign ctrl_wr = reg_wr && strap_loaded && addr_hit(reg_addr, `REG_PORT3_CTRL);
   assign low_wr = reg_wr && strap_loaded && addr_hit(reg_addr, `REG_STORM_LOW);

   // Each strap-backed bit takes its pin once; a later write overrides it like any other bit.
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         port3_flow_control_en <= `FLOW_RST;
      else if (strap_capture)
         port3_flow_control_en <= strap_sync[0];
      else if (ctrl_wr)
         port3_flow_control_en <= reg_wdata[`FLOW_BIT];
   end

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         port3_speed_10 <= `SPEED_RST;
      else if (strap_capture)
         port3_speed_10 <= strap_sync[1];
      else if (ctrl_wr)
         port3_speed_10 <= reg_wdata[`SPEED_BIT];
   end

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         port3_half_duplex <= `DUPLEX_RST;
      else if (strap_capture)
         port3_half_duplex <= strap_sync[2];
      else if (ctrl_wr)
         port3_half_duplex <= reg_wdata[`DUPLEX_BIT];
   end

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         null_vid_replace <= `NULL_VID_RST;
      else if (ctrl_wr)
         null_vid_replace <= reg_wdata[`NULL_VID_BIT];
   end

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         storm_high <= `STORM_HIGH_RST;
      else if (ctrl_wr)
         storm_high <= reg_wdata[`STORM_HIGH_MSB:0];
   end

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
         storm_low <= `STORM_LOW_RST;
      else if (low_wr)
         storm_low <= reg_wdata;
   end

   assign storm_threshold = {storm_high, storm_low};

   // Bit 7 is reserved and always reads zero.
   assign ctrl_image = {1'b0, port3_half_duplex, port3_flow_control_en, port3_speed_10,
                        null_vid_replace, storm_high};

   // Read decode; the factory-test registers are constants and have no write path.
   always @*
   begin
      if (addr_hit(reg_addr, `REG_PORT3_CTRL))
         next_rdata = ctrl_image;
      else if (addr_hit(reg_addr, `REG_STORM_LOW))
         next_rdata = storm_low;
      else if (addr_hit(reg_addr, `REG_FACTORY_A))
         next_rdata = `FACTORY_A_VAL;
      else if (addr_hit(reg_addr, `REG_FACTORY_B))
         next_rdata = `FACTORY_B_VAL;
      else if (addr_hit(reg_addr, `REG_FACTORY_C))
         next_rdata = `FACTORY_C_VAL;
      else
         next_rdata = `UNMAPPED_VAL;
   end

   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         reg_rdata <= 8'h00;
         reg_rvalid <= 1'b0;
      end
      else
      begin
         reg_rvalid <= reg_rd;
         if (reg_rd)
            reg_rdata <= next_rdata;
      end
   end

   // The CPU port is the highest index and takes its rate from the control register.
   assign speed_vec = {port3_speed_10, port_speed_10};

   // One limiter per input port; all of them share the single threshold held in this bank.
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p = p + 1)
      begin : g_port
         storm_limiter #(
            .CNT_W(CNT_W),
            .PERIOD_FAST_CYC(FAST_CYC),
            .PERIOD_SLOW_CYC(SLOW_CYC)
         ) u_limiter (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .speed_10(speed_vec[p]),
            .threshold(storm_threshold),
            .block_in(bcast_block[p]),
            .block_drop(bcast_drop[p]),
            .period_start(storm_period_start[p])
         );
      end
   endgenerate
endmodule // switch_global_control_regs
`default_nettype wire

// *** dv/switch_global_control_regs_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module gcr_checker #(parameter NUM_PORTS = 3) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   input wire logic flow_control_strap_pin,
   input wire logic cpu_port_speed_strap_pin,
   input wire logic duplex_strap_pin,
   input wire logic [NUM_PORTS-1:0] bcast_block,
   input wire logic [NUM_PORTS-1:0] bcast_drop,
   input wire logic port3_flow_control_en,
   input wire logic port3_speed_10,
   input wire logic port3_half_duplex,
   input wire logic null_vid_replace,
   input wire logic [10:0] storm_threshold,
   input wire logic strap_loaded
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);
   // Writes before the straps land are dropped, so they must not be checked.
   logic wr_ok;
   assign wr_ok = reg_wr && strap_loaded;
   chk_read_answer:
   assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
   chk_test_b:
   assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata == 8'h24) else $error("bad test b");
   chk_test_c:
   assert property (reg_rd && reg_addr == 8'h0a |=> reg_rdata == 8'h35) else $error("bad test c");
   chk_control_write:
   assert property (wr_ok && reg_addr == 8'h06 |=> {1'b0, port3_half_duplex, port3_flow_control_en,
      port3_speed_10, null_vid_replace, storm_threshold[10:8]} == ($past(reg_wdata) & 8'h7f))
      else $error("bad control write");
   chk_low_write:
   assert property (wr_ok && reg_addr == 8'h07 |=> storm_threshold[7:0] == $past(reg_wdata))
      else $error("bad low write");
   chk_flow_strap:
   assert property ($rose(strap_loaded) |-> port3_flow_control_en == flow_control_strap_pin)
      else $error("bad flow strap");
   chk_speed_strap:
   assert property ($rose(strap_loaded) |-> port3_speed_10 == cpu_port_speed_strap_pin)
      else $error("bad speed strap");
   chk_duplex_strap:
   assert property ($rose(strap_loaded) |-> port3_half_duplex == duplex_strap_pin)
      else $error("bad duplex strap");
   chk_zero_drop:
   assert property (storm_threshold == 11'h000 && bcast_block[0] |=> bcast_drop[0])
      else $error("block passed");
   cover property (wr_ok && reg_addr == 8'h07);
   cover property (bcast_drop[0]);
   cover property ($rose(strap_loaded));
endmodule // gcr_checker
bind switch_global_control_regs gcr_checker #(.NUM_PORTS(NUM_PORTS)) gcr_checker_i (.*);
`default_nettype wire

// *** dv/switch_global_control_regs_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module switch_global_control_regs_tb_top;
   logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, fc = 0, sp = 0, dx = 0;
   logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
   logic [1:0] port_speed_10 = 0;
   logic [2:0] bcast_block = 0, bcast_drop, pstart;
   logic flow, spd, half, nvid, loaded, rvalid;
   logic [10:0] thr;
   logic [31:0] seed = 32'h0001_251f;
   logic [7:0] ra[5] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h3c};
   logic [7:0] rv[5] = '{8'h63, 8'h00, 8'h24, 8'h35, 8'h00};
   int mismatches = 0, n_compared = 0, i, n;
   always #2 sys_clk = ~sys_clk;
   switch_global_control_regs #(.PERIOD_100_CYC(40), .PERIOD_10_CYC(100)) switch_global_control_regs_i (
      .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(rvalid), .flow_control_strap_pin(fc),
      .cpu_port_speed_strap_pin(sp), .duplex_strap_pin(dx), .port_speed_10(port_speed_10),
      .bcast_block(bcast_block), .bcast_drop(bcast_drop), .storm_period_start(pstart),
      .port3_flow_control_en(flow), .port3_speed_10(spd), .port3_half_duplex(half),
      .null_vid_replace(nvid), .storm_threshold(thr), .strap_loaded(loaded));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int drops(int k, int t);
      return k > t ? k - t : 0;
   endfunction
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1;
      @(posedge sys_clk);
      reg_wr <= 0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1;
      @(posedge sys_clk);
      reg_rd <= 0;
      #1;
      `CHK(rvalid, 1'b1)
      `CHK(reg_rdata, e)
   endtask
   // Samples a little after the edge so the registered pulse has settled.
   task automatic wait_pulse(int p);
      n = 0;
      do begin
         @(posedge sys_clk);
         #1;
         n++;
      end while (pstart[p] !== 1'b1 && n < 300);
   endtask
   // Two syncs first, since the boundary in flight may still use the old rate.
   task automatic period(int p, int e);
      repeat (3) wait_pulse(p);
      `CHK(n, e)
   endtask
   task automatic storm(int p, logic [10:0] t);
      wr(8'h06, {5'h00, t[10:8]});
      wr(8'h07, t[7:0]);
      wait_pulse(p);
      n = 0;
      for (i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         bcast_block <= (i < 6) ? (3'h1 << p) : 3'h0;
         #1;
         n += (bcast_drop[p] === 1'b1);
      end
      `CHK(n, drops(6, t))
   endtask
   task stop_test;
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      void'(rnd());
      {fc, sp, dx} = seed[2:0];
      repeat (6) @(posedge sys_clk);
      rstn <= 1;
      repeat (4) @(posedge sys_clk);
      #1;
      `CHK({loaded, flow, spd, half}, {1'b1, fc, sp, dx})
      `CHK({nvid, thr}, 12'h063)
      rd(8'h06, {1'b0, dx, fc, sp, 4'h0});
      for (i = 0; i < 5; i++) rd(ra[i], rv[i]);
      for (i = 1; i < 4; i++)
      begin
         wr(ra[i], 8'(rnd()));
         rd(ra[i], rv[i]);
      end
      for (i = 0; i < 8; i++)
      begin
         void'(rnd());
         wr(8'h06, seed[7:0]);
         wr(8'h07, seed[15:8]);
         port_speed_10 <= seed[9:8];
         #1;
         `CHK({half, flow, spd, nvid, thr}, {seed[6:0], seed[15:8]})
         rd(8'h06, seed[7:0] & 8'h7f);
      end
      @(posedge sys_clk);
      port_speed_10 <= 2'h0;
      period(0, 40);
      @(posedge sys_clk);
      port_speed_10 <= 2'h1;
      period(0, 100);
      period(1, 40);
      wr(8'h06, 8'h10);
      period(2, 100);
      storm(0, 11'h003);
      storm(1, 11'h000);
      storm(2, 11'h006);
      storm(int'(rnd() % 3), 11'(rnd() % 9));
      stop_test;
   end
   initial
   begin
      #40000;
      mismatches++;
      stop_test;
   end
endmodule // switch_global_control_regs_tb_top
`default_nettype wire
